// file: rtl/rtcc_ctrl.sv
`timescale 1ns/1ps
`include "rtcc_defs.svh"
module rtcc_ctrl
	import rtcc_pkg::*;
#(
	parameter int unsigned UPDATE_CYCLES = `RTCC_UPD_CYCLES
) (
	// Clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	// Pins from outside
	input  wire logic       OSCILLATOR_INPUT,
	input  wire logic       POWER_SENSE_RESET_N,
	input  wire logic       SECONDARY_RESET,
	// Host index/data port
	input  wire logic       HOST_INDEX_WR,
	input  wire logic       HOST_DATA_WR,
	input  wire logic       HOST_DATA_RD,
	input  wire logic [7:0] HOST_WDATA,
	output logic      [7:0] HOST_RDATA,
	output logic            HOST_RDATA_VALID,
	// Clock interrupt request
	output logic            CLK_IRQ
);
	localparam logic [`RTCC_UPD_CNT_W-1:0] UPD_LAST = `RTCC_UPD_CNT_W'(UPDATE_CYCLES - 1);
	localparam logic [2:0]                 PIN_RST  = `RTCC_PIN_RST;

	// Shift of the chosen base above the 32.768 kHz chain
	function automatic logic [4:0] base_shift(input logic [2:0] dv);
		case (dv)
			`RTCC_DV_4M: base_shift = `RTCC_SHIFT_4M;
			`RTCC_DV_1M: base_shift = `RTCC_SHIFT_1M;
			default:     base_shift = `RTCC_SHIFT_32K;
		endcase
	endfunction

	function automatic logic [`RTCC_DIV_W-1:0] low_mask(input logic [4:0] k);
		low_mask = (`RTCC_DIV_W'(1) << k) - `RTCC_DIV_W'(1);
	endfunction

	// BCD increment with wrap at top; msb says wrapped
	function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top);
		if (v >= top)
			bcd_step = {1'b1, 8'h00};
		else if (v[3:0] >= 4'h9)
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		else
			bcd_step = {1'b0, v + 8'h01};
	endfunction

	function automatic logic alm_match(input logic [7:0] t, input logic [7:0] a);
		alm_match = (a[7:6] == 2'b11) || (a == t);
	endfunction

	// Pin synchronisers; a level counts once stages two and three agree
	logic [2:0] pin_in;
	logic [2:0] s1_r, s2_r, s3_r, lvl_r;
	assign pin_in = {SECONDARY_RESET, POWER_SENSE_RESET_N, OSCILLATOR_INPUT};
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_sync
			always_ff @(posedge CORE_CLK or negedge RST_N) begin
				if (!RST_N) begin
					s1_r[g]  <= PIN_RST[g];
					s2_r[g]  <= PIN_RST[g];
					s3_r[g]  <= PIN_RST[g];
					lvl_r[g] <= PIN_RST[g];
				end else begin
					s1_r[g] <= pin_in[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g])
						lvl_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate

	logic osc_prev_r;
	logic osc_rise, psr_low, sec_rst;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			osc_prev_r <= 1'b0;
		else
			osc_prev_r <= lvl_r[0];
	end
	assign osc_rise = lvl_r[0] & ~osc_prev_r;
	assign psr_low  = ~lvl_r[1];
	assign sec_rst  = lvl_r[2];

	// Host strobes decoded against the held index
	logic [6:0] idx_r;
	logic       rate_wr, ctl_wr, flag_rd, valid_rd, set_wr;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			idx_r <= 7'h00;
		else if (HOST_INDEX_WR)
			idx_r <= HOST_WDATA[6:0];
	end
	assign rate_wr  = HOST_DATA_WR && idx_r == `RTCC_IDX_RATE;
	assign ctl_wr   = HOST_DATA_WR && idx_r == `RTCC_IDX_CTRL;
	assign flag_rd  = HOST_DATA_RD && idx_r == `RTCC_IDX_FLAGS;
	assign valid_rd = HOST_DATA_RD && idx_r == `RTCC_IDX_VALID;
	assign set_wr   = ctl_wr && HOST_WDATA[`RTCC_CTL_SET];

	// Rate and prescaler select, untouched by either reset pin
	logic [3:0] rs_r;
	logic [2:0] dv_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rs_r <= `RTCC_RS_RST;
			dv_r <= `RTCC_DV_RST;
		end else if (rate_wr) begin
			rs_r <= HOST_WDATA[3:0];
			dv_r <= HOST_WDATA[6:4];
		end
	end

	// Control bits kept through the reset pins
	logic set_r, hr24_r, dse_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			set_r  <= 1'b0;
			hr24_r <= 1'b0;
			dse_r  <= 1'b0;
		end else if (ctl_wr) begin
			set_r  <= HOST_WDATA[`RTCC_CTL_SET];
			hr24_r <= HOST_WDATA[`RTCC_CTL_HR24];
			dse_r  <= HOST_WDATA[`RTCC_CTL_DSE];
		end
	end

	// Interrupt enables with their reset behaviour
	logic pie_r, aie_r, uie_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pie_r <= 1'b0;
			aie_r <= 1'b0;
			uie_r <= 1'b0;
		end else begin
			if (psr_low || sec_rst)
				pie_r <= 1'b0;
			else if (ctl_wr)
				pie_r <= HOST_WDATA[`RTCC_CTL_PIE];
			if (psr_low)
				aie_r <= 1'b0;
			else if (ctl_wr)
				aie_r <= HOST_WDATA[`RTCC_CTL_AIE];
			if (psr_low || (set_wr && !set_r))
				uie_r <= 1'b0;
			else if (ctl_wr)
				uie_r <= HOST_WDATA[`RTCC_CTL_UIE];
		end
	end

	// Divider chain counting oscillator edges; 11X and unlisted codes hold it at zero
	logic                   div_run;
	logic [4:0]             shift, rate_k, sec_k;
	logic [`RTCC_DIV_W-1:0] div_r, div_nxt, remain;
	logic                   per_evt, sec_evt, in_lead;
	assign div_run = dv_r == `RTCC_DV_4M || dv_r == `RTCC_DV_1M || dv_r == `RTCC_DV_32K;
	assign shift   = base_shift(dv_r);
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			div_r <= '0;
		else if (!div_run)
			div_r <= '0;
		else if (osc_rise)
			div_r <= div_nxt;
	end
	assign div_nxt = div_r + `RTCC_DIV_W'(1);

	// Periodic tap: slow base moves codes one and two up the chain
	always_comb begin
		if (rs_r == 4'h0)
			rate_k = 5'h00;
		else if (dv_r == `RTCC_DV_32K && rs_r < 4'h3)
			rate_k = {1'b0, rs_r + `RTCC_SLOW_RS_ADD} - 5'h01 + shift;
		else
			rate_k = {1'b0, rs_r} - 5'h01 + shift;
	end
	assign per_evt = div_run && osc_rise && rate_k != 5'h00 && (div_nxt & low_mask(rate_k)) == '0;
	assign sec_k   = `RTCC_SEC_BITS + shift;
	assign sec_evt = div_run && osc_rise && (div_nxt & low_mask(sec_k)) == '0;
	assign remain  = low_mask(sec_k) - (div_r & low_mask(sec_k)) + `RTCC_DIV_W'(1);
	assign in_lead = div_run && remain <= (`RTCC_DIV_W'(`RTCC_UIP_LEAD_TICKS) << shift);

	// Update cycle sequencer
	rtcc_upd_state_t             state_r;
	logic [`RTCC_UPD_CNT_W-1:0]  upd_cnt_r;
	logic                        upd_ok, upd_start, upd_end;
	assign upd_ok    = div_run && !set_r;
	assign upd_start = state_r == RTCC_IDLE && sec_evt && upd_ok;
	assign upd_end   = state_r == RTCC_BUSY && !set_r && upd_cnt_r == UPD_LAST;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r   <= RTCC_IDLE;
			upd_cnt_r <= '0;
		end else begin
			unique case (state_r)
				RTCC_IDLE: begin
					upd_cnt_r <= '0;
					if (upd_start)
						state_r <= RTCC_BUSY;
				end
				RTCC_BUSY: begin
					upd_cnt_r <= upd_cnt_r + `RTCC_UPD_CNT_W'(1);
					if (set_r || upd_end)
						state_r <= RTCC_IDLE;
				end
			endcase
		end
	end

	// Progress bit: lead window plus busy, cleared by an inhibit write
	logic uip_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			uip_r <= 1'b0;
		else
			uip_r <= !set_wr && upd_ok && (in_lead || (state_r == RTCC_BUSY && !upd_end));
	end

	// Next time of day, including daylight saving exceptions
	rtcc_mem_if mif ();
	rtcc_byte_t                 t_sec, t_min, t_hr, t_dow, t_date, t_mon;
	logic [8:0]                 sec_s, min_s, hr_s, dow_s, hr12_s;
	logic                       at_159, spring, fall, dst_back_r;
	logic [`RTCC_TIME_W-1:0]    new_time;
	assign t_sec  = mif.bytes[`RTCC_B_SEC*8 +: 8];
	assign t_min  = mif.bytes[`RTCC_B_MIN*8 +: 8];
	assign t_hr   = mif.bytes[`RTCC_B_HR*8 +: 8];
	assign t_dow  = mif.bytes[`RTCC_B_DOW*8 +: 8];
	assign t_date = mif.bytes[`RTCC_B_DATE*8 +: 8];
	assign t_mon  = mif.bytes[`RTCC_B_MON*8 +: 8];
	assign at_159 = dse_r && t_sec == 8'h59 && t_min == 8'h59 && t_hr == 8'h01 && t_dow == 8'h01 && t_date >= 8'h25;
	assign spring = at_159 && t_mon == 8'h04;
	assign fall   = at_159 && t_mon == 8'h10 && !dst_back_r;
	always_comb begin
		hr12_s = bcd_step({1'b0, t_hr[6:0]}, 8'h99);
		sec_s = bcd_step(t_sec, 8'h59);
		min_s = bcd_step(t_min, 8'h59);
		dow_s = bcd_step(t_dow, 8'h07);
		if (hr24_r)
			hr_s = bcd_step(t_hr, 8'h23);
		else if (t_hr[6:0] == 7'h11)
			hr_s = {t_hr[7], ~t_hr[7], 7'h12};
		else if (t_hr[6:0] >= 7'h12)
			hr_s = {1'b0, t_hr[7], 7'h01};
		else
			hr_s = {1'b0, t_hr[7], hr12_s[6:0]};
		new_time = mif.bytes;
		new_time[`RTCC_B_SEC*8 +: 8] = sec_s[7:0];
		if (sec_s[8]) begin
			new_time[`RTCC_B_MIN*8 +: 8] = min_s[7:0];
			if (min_s[8]) begin
				new_time[`RTCC_B_HR*8 +: 8] = spring ? 8'h03 : fall ? 8'h01 : hr_s[7:0];
				if (hr_s[8] && !spring && !fall)
					new_time[`RTCC_B_DOW*8 +: 8] = dow_s[8] ? 8'h01 : dow_s[7:0];
			end
		end
	end

	// One fall-back per October night
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			dst_back_r <= 1'b0;
		else if (upd_start && fall)
			dst_back_r <= 1'b1;
		else if (upd_start && new_time[`RTCC_B_HR*8 +: 8] == 8'h02)
			dst_back_r <= 1'b0;
	end

	// Alarm comparison on the freshly updated time
	logic alarm_hit;
	assign alarm_hit = alm_match(new_time[`RTCC_B_SEC*8 +: 8], mif.bytes[`RTCC_B_SEC_ALM*8 +: 8])
		&& alm_match(new_time[`RTCC_B_MIN*8 +: 8], mif.bytes[`RTCC_B_MIN_ALM*8 +: 8])
		&& alm_match(new_time[`RTCC_B_HR*8 +: 8], mif.bytes[`RTCC_B_HR_ALM*8 +: 8]);

	// Storage port; time bytes closed to the host while busy
	logic blocked;
	assign blocked        = state_r == RTCC_BUSY && idx_r < 7'(`RTCC_TIME_BYTES);
	assign mif.host_addr  = idx_r[3:0];
	assign mif.host_we    = HOST_DATA_WR && idx_r < 7'(`RTCC_TIME_BYTES) && !blocked;
	assign mif.host_wdata = HOST_WDATA;
	assign mif.upd_we     = upd_start;
	assign mif.upd_bytes  = new_time;
	rtcc_time_mem u_mem (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.mif   (mif)
	);

	// Event flags; a set in the clearing cycle survives
	logic pf_r, af_r, uf_r, summary_irq_flag;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pf_r <= 1'b0;
			af_r <= 1'b0;
			uf_r <= 1'b0;
		end else if (psr_low) begin
			pf_r <= 1'b0;
			af_r <= 1'b0;
			uf_r <= 1'b0;
		end else begin
			pf_r <= per_evt || (pf_r && !flag_rd);
			af_r <= (upd_start && alarm_hit) || (af_r && !flag_rd);
			uf_r <= upd_end || (uf_r && !flag_rd);
		end
	end
	assign summary_irq_flag = (pf_r && pie_r) || (af_r && aie_r) || (uf_r && uie_r);

	// Validity bit
	logic vrt_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			vrt_r <= 1'b0;
		else if (psr_low)
			vrt_r <= 1'b0;
		else if (valid_rd)
			vrt_r <= 1'b1;
	end

	// Read path: value picked at the strobe, returned one edge later
	logic       rd1_r, rmem_r;
	rtcc_byte_t rval_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd1_r            <= 1'b0;
			rmem_r           <= 1'b0;
			rval_r           <= 8'h00;
			HOST_RDATA       <= 8'h00;
			HOST_RDATA_VALID <= 1'b0;
		end else begin
			rd1_r  <= HOST_DATA_RD;
			rmem_r <= idx_r < 7'(`RTCC_TIME_BYTES) && !blocked;
			unique case (idx_r)
				`RTCC_IDX_RATE:  rval_r <= {uip_r, dv_r, rs_r};
				`RTCC_IDX_CTRL:  rval_r <= {set_r, pie_r, aie_r, uie_r, 2'b00, hr24_r, dse_r};
				`RTCC_IDX_FLAGS: rval_r <= {summary_irq_flag, pf_r, af_r, uf_r, 4'h0};
				`RTCC_IDX_VALID: rval_r <= {vrt_r, 7'h00};
				default:         rval_r <= 8'h00;
			endcase
			if (rd1_r)
				HOST_RDATA <= rmem_r ? mif.host_rdata : rval_r; // Holds until the next answer
			HOST_RDATA_VALID <= rd1_r;
		end
	end

	// Single request output
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			CLK_IRQ <= 1'b0;
		else
			CLK_IRQ <= summary_irq_flag;
	end

	default clocking dcb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	flag_read_clr_a: assert property (flag_rd && !psr_low && !per_evt && !upd_start && !upd_end
		|=> !pf_r && !af_r && !uf_r) else $error("flags not cleared by read");
	flag_low_zero_a: assert property (flag_rd ##1 !HOST_DATA_RD |=> HOST_RDATA_VALID && HOST_RDATA[3:0] == 4'h0)
		else $error("flag read answer wrong");
	psr_clear_a: assert property (psr_low |=> !pie_r && !aie_r && !uie_r && !pf_r && !af_r && !uf_r && !vrt_r)
		else $error("power-sense reset left state");
	psr_irq_off_a: assert property (psr_low ##1 psr_low |=> !CLK_IRQ) else $error("request kept in reset");
	set_abort_a: assert property (set_r |=> state_r == RTCC_IDLE && !uip_r) else $error("inhibit ignored");
	uie_set_clr_a: assert property ($rose(set_r) |-> !uie_r) else $error("update enable kept on inhibit");
	end_flags_a: assert property (upd_end && !psr_low |=> uf_r && !uip_r && state_r == RTCC_IDLE)
		else $error("update end not flagged");
	rate_none_a: assert property (rs_r == 4'h0 |-> !per_evt) else $error("periodic event with rate zero");
	pie_gate_a: assert property (!pie_r && !(af_r && aie_r) && !(uf_r && uie_r) |-> !summary_irq_flag)
		else $error("periodic irq not gated");
	irq_follow_a: assert property (summary_irq_flag ##1 summary_irq_flag |-> CLK_IRQ) else $error("request not asserted");
	uip_lead_a: assert property ($rose(state_r == RTCC_BUSY) |-> $past(uip_r)) else $error("update without lead");
	busy_block_a: assert property (state_r == RTCC_BUSY && !mif.upd_we |=> $stable(mif.bytes))
		else $error("time bytes changed while busy");
	vrt_set_a: assert property (valid_rd && !psr_low ##1 !psr_low |-> vrt_r) else $error("validity not set");
endmodule

// file: rtl/rtcc_defs.svh
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH

// Register indices on the data port
`define RTCC_IDX_RATE        7'h0A
`define RTCC_IDX_CTRL        7'h0B
`define RTCC_IDX_FLAGS       7'h0C
`define RTCC_IDX_VALID       7'h0D
`define RTCC_TIME_BYTES      10
`define RTCC_TIME_W          80

// Time and alarm byte positions
`define RTCC_B_SEC           0
`define RTCC_B_SEC_ALM       1
`define RTCC_B_MIN           2
`define RTCC_B_MIN_ALM       3
`define RTCC_B_HR            4
`define RTCC_B_HR_ALM        5
`define RTCC_B_DOW           6
`define RTCC_B_DATE          7
`define RTCC_B_MON           8

// Control register fields
`define RTCC_CTL_SET         7
`define RTCC_CTL_PIE         6
`define RTCC_CTL_AIE         5
`define RTCC_CTL_UIE         4
`define RTCC_CTL_HR24        1
`define RTCC_CTL_DSE         0

// Reset values of loose control state
`define RTCC_RS_RST          4'h0
`define RTCC_DV_RST          3'h2
`define RTCC_PIN_RST         3'h2

// Prescaler codes and their shift above the 32.768 kHz chain
`define RTCC_DV_4M           3'h0
`define RTCC_DV_1M           3'h1
`define RTCC_DV_32K          3'h2
`define RTCC_SHIFT_4M        5'h07
`define RTCC_SHIFT_1M        5'h05
`define RTCC_SHIFT_32K       5'h00
`define RTCC_SEC_BITS        5'h0F
`define RTCC_SLOW_RS_ADD     4'h7
`define RTCC_DIV_W           22

// Timing
`define RTCC_TBASE_HZ        32768
`define RTCC_UIP_LEAD_US     244
`define RTCC_UIP_LEAD_TICKS  ((`RTCC_UIP_LEAD_US * `RTCC_TBASE_HZ + 999999) / 1000000)
`define RTCC_CLK_MHZ         250
`define RTCC_UPD_US          2000
`define RTCC_UPD_CYCLES      (`RTCC_UPD_US * `RTCC_CLK_MHZ)
`define RTCC_UPD_CNT_W       20

`endif

// file: rtl/rtcc_mem_if.sv
`timescale 1ns/1ps
`include "rtcc_defs.svh"
interface rtcc_mem_if;
	logic [3:0]              host_addr;
	logic                    host_we;
	logic [7:0]              host_wdata;
	logic [7:0]              host_rdata;
	logic                    upd_we;
	logic [`RTCC_TIME_W-1:0] upd_bytes;
	logic [`RTCC_TIME_W-1:0] bytes;
	modport ctl (output host_addr, host_we, host_wdata, upd_we, upd_bytes, input host_rdata, bytes);
	modport mem (input host_addr, host_we, host_wdata, upd_we, upd_bytes, output host_rdata, bytes);
endinterface

// file: rtl/rtcc_pkg.sv
package rtcc_pkg;
	typedef enum logic {RTCC_IDLE, RTCC_BUSY} rtcc_upd_state_t;
	typedef logic [7:0] rtcc_byte_t;
endpackage

// file: rtl/rtcc_time_mem.sv
`timescale 1ns/1ps
`include "rtcc_defs.svh"
module rtcc_time_mem
	import rtcc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Storage port
	rtcc_mem_if.mem  mif
);
	rtcc_byte_t mem_r [0:`RTCC_TIME_BYTES-1];

	// One register per byte, update write wins over host write
	genvar i;
	generate
		for (i = 0; i < `RTCC_TIME_BYTES; i++) begin : g_byte
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					mem_r[i] <= 8'h00;
				end else if (mif.upd_we) begin
					mem_r[i] <= mif.upd_bytes[i*8 +: 8];
				end else if (mif.host_we && mif.host_addr == 4'(i)) begin
					mem_r[i] <= (i == `RTCC_B_SEC) ? {1'b0, mif.host_wdata[6:0]} : mif.host_wdata;
				end
			end
			assign mif.bytes[i*8 +: 8] = mem_r[i];
		end
	endgenerate

	// Registered read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mif.host_rdata <= 8'h00;
		end else if (mif.host_addr < 4'(`RTCC_TIME_BYTES)) begin
			mif.host_rdata <= mem_r[mif.host_addr];
		end else begin
			mif.host_rdata <= 8'h00;
		end
	end
endmodule

// file: tb/rtcc_host_model.sv
`timescale 1ns/1ps
module rtcc_host_model (
	// Clock
	input  wire logic       clk,
	// Strobes and data towards the device
	output logic            index_wr,
	output logic            data_wr,
	output logic            data_rd,
	output logic      [7:0] wdata,
	// Answer from the device
	input  wire logic [7:0] rdata,
	input  wire logic       rdata_valid
);
	// Strobes idle at time zero
	initial begin
		index_wr = 1'b0;
		data_wr  = 1'b0;
		data_rd  = 1'b0;
		wdata    = 8'hA5;
	end

	// Index strobe then data strobe, short enough to finish well inside the warning lead
	task automatic access(input logic [6:0] idx, input logic rd, input logic [7:0] d, output logic [7:0] q);
		int n;
		q = 8'h00;
		@(posedge clk);
		index_wr <= 1'b1;
		wdata    <= {1'b0, idx};
		@(posedge clk);
		index_wr <= 1'b0;
		data_wr  <= ~rd;
		data_rd  <= rd;
		wdata    <= d;
		@(posedge clk);
		data_wr  <= 1'b0;
		data_rd  <= 1'b0;
		wdata    <= ~d; // Released bus does not keep the last value
		if (rd) begin
			q = 8'hXX;
			for (n = 0; n < 8; n++) begin
				@(posedge clk);
				if (rdata_valid === 1'b1) begin
					q = rdata;
					break;
				end
			end
		end
	endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
	import rtcc_pkg::*;
	logic       core_clk;
	logic       rst_n;
	logic       osc = 1'b0;
	logic       psr_n;
	logic       sec_rst;
	logic       index_wr;
	logic       data_wr;
	logic       data_rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       rdata_valid;
	logic       clk_irq;
	logic [7:0] q;
	int         n_mismatch;
	int         n_compared;
	int         osc_cnt = 0;
	int         i;
	logic [6:0] t_idx [4] = '{7'h00, 7'h01, 7'h0E, 7'h7F};
	logic [7:0] t_wr  [4] = '{8'hFF, 8'h55, 8'h5A, 8'h33};
	logic [7:0] t_exp [4] = '{8'h7F, 8'h55, 8'h00, 8'h00};
	logic [7:0] p_ctl [2] = '{8'h73, 8'hE3};
	logic [7:0] p_exp [2] = '{8'h03, 8'h83};

	// Core clock, 4 ns
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Time base, four core cycles a period
	always @(posedge core_clk) begin
		osc_cnt <= osc_cnt + 1;
		if (osc_cnt[0]) begin
			osc <= ~osc;
		end
	end

	rtcc_ctrl #(.UPDATE_CYCLES(20)) rtcc_ctrl_inst (
		.CORE_CLK           (core_clk),
		.RST_N              (rst_n),
		.OSCILLATOR_INPUT   (osc),
		.POWER_SENSE_RESET_N(psr_n),
		.SECONDARY_RESET    (sec_rst),
		.HOST_INDEX_WR      (index_wr),
		.HOST_DATA_WR       (data_wr),
		.HOST_DATA_RD       (data_rd),
		.HOST_WDATA         (wdata),
		.HOST_RDATA         (rdata),
		.HOST_RDATA_VALID   (rdata_valid),
		.CLK_IRQ            (clk_irq)
	);

	rtcc_host_model rtcc_host_model_inst (
		.clk        (core_clk),
		.index_wr   (index_wr),
		.data_wr    (data_wr),
		.data_rd    (data_rd),
		.wdata      (wdata),
		.rdata      (rdata),
		.rdata_valid(rdata_valid)
	);

	// Compare and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		rtcc_host_model_inst.access(idx, 1'b0, d, q);
	endtask

	task automatic rd(input string what, input logic [6:0] idx, input logic [7:0] m, input logic [7:0] exp);
		rtcc_host_model_inst.access(idx, 1'b1, 8'h00, q);
		chk(what, q & m, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Counts and verdict
	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (30000) @(posedge core_clk);
		n_mismatch++;
		$display("watchdog expired");
		end_sim();
	end

	// Main sequence
	initial begin
		rst_n      = 1'b0;
		psr_n      = 1'b0;
		sec_rst    = 1'b0;
		n_mismatch = 0;
		n_compared = 0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		psr_n <= 1'b1;
		cyc(8);
		rd("ctrl", 7'h0B, 8'hFF, 8'h00);
		rd("flags", 7'h0C, 8'hFF, 8'h00);
		rd("rate", 7'h0A, 8'hFF, 8'h20);
		rd("valid", 7'h0D, 8'hFF, 8'h00);
		rd("valid", 7'h0D, 8'hFF, 8'h80);
		wr(7'h0D, 8'h00);
		rd("valid", 7'h0D, 8'hFF, 8'h80);
		$display("test reset done");

		wr(7'h0B, 8'hFF);
		rd("ctrl", 7'h0B, 8'hFF, 8'hE3);
		rd("progress", 7'h0A, 8'h80, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(t_idx[i], t_wr[i]);
			rd("bytes", t_idx[i], 8'hFF, t_exp[i]);
		end
		wr(7'h0B, 8'h00);
		rd("ctrl", 7'h0B, 8'hFF, 8'h00);
		$display("test control done");

		wr(7'h0A, 8'h01);
		rtcc_host_model_inst.access(7'h0C, 1'b1, 8'h00, q);
		cyc(700);
		chk("irq", {7'h00, clk_irq}, 8'h00);
		rd("flags", 7'h0C, 8'hFF, 8'h40);
		wr(7'h0B, 8'h40);
		cyc(700);
		chk("irq", {7'h00, clk_irq}, 8'h01);
		wr(7'h0A, 8'h00);
		rd("flags", 7'h0C, 8'hFF, 8'hC0);
		chk("irq", {7'h00, clk_irq}, 8'h00);
		cyc(1200);
		rd("flags", 7'h0C, 8'hFF, 8'h00);
		wr(7'h0C, 8'hFF);
		rd("flags", 7'h0C, 8'hFF, 8'h00);
		rd("rate", 7'h0A, 8'h7F, 8'h00);
		$display("test periodic done");

		wr(7'h0B, 8'h73);
		sec_rst <= 1'b1;
		cyc(8);
		sec_rst <= 1'b0;
		cyc(8);
		rd("ctrl", 7'h0B, 8'hFF, 8'h33);
		for (i = 0; i < 2; i++) begin
			wr(7'h0B, p_ctl[i]);
			wr(7'h0A, 8'h01);
			cyc(700);
			psr_n <= 1'b0;
			cyc(10);
			wr(7'h0A, 8'h00);
			psr_n <= 1'b1;
			cyc(8);
			chk("irq", {7'h00, clk_irq}, 8'h00);
			rd("ctrl", 7'h0B, 8'hFF, p_exp[i]);
			rd("flags", 7'h0C, 8'hFF, 8'h00);
			rd("valid", 7'h0D, 8'hFF, 8'h00);
			rd("rate", 7'h0A, 8'h7F, 8'h00);
		end
		$display("test power sense done");
		end_sim();
	end
endmodule
